// >>> isa_pkg.sv
// shared constants and types for the two-wire status and address register block
package isa_pkg;

    // register map, byte addresses on the register port
    localparam logic [7:0] OFS_SECOND_ADDR = 8'h0c;
    localparam logic [7:0] OFS_DATA_BUF = 8'h10;
    localparam logic [7:0] OFS_STATUS0 = 8'h14;

    // reset values
    localparam logic [15:0] RST_SECOND_ADDR = 16'h0000;
    localparam logic [7:0] RST_DATA_BUF = 8'h00;
    localparam logic [15:0] RST_STATUS0 = 16'h0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // second_slave_address fields
    localparam int DUAL_EN_BIT = 0;
    localparam int ADDR2_LSB = 1;
    localparam int ADDR2_MSB = 7;

    // transfer_status_0 fields
    localparam int BIT_ALERT = 15;
    localparam int BIT_TIMEOUT = 14;
    localparam int BIT_PEC = 12;
    localparam int BIT_OVR_UND = 11;
    localparam int BIT_ACK_ERR = 10;
    localparam int BIT_ARB_LOST = 9;
    localparam int BIT_BUS_ERR = 8;
    localparam int BIT_TBE = 7;
    localparam int BIT_RX_BUFFER_NOT_EMPTY = 6;
    // flags cleared by writing zero
    localparam logic [15:0] CLEAR_W0_MASK = 16'hdf00;

    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 1000;
    localparam int TIMEOUT_MS = 25;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMEOUT_TICKS = (TIMEOUT_MS * 1000000) / TICK_NS;
    localparam int TICK_W = 16;

    // inputs from the bus protocol engine
    typedef struct packed {
        logic addrValid;
        logic [7:0] addrByte;
        logic rxByteDone;
        logic [7:0] rxByte;
        logic txByteTaken;
        logic txShiftDone;
        logic shiftEmpty;
        logic alertDetected;
        logic pecMismatch;
        logic ackMissing;
        logic arbLost;
        logic badStartStop;
    } isa_engine_t;

    // mode levels from the control side
    typedef struct packed {
        logic smbusMode;
        logic smbusHost;
        logic stretchDisable;
        logic slaveRx;
        logic slaveTx;
        logic isMaster;
    } isa_mode_t;

endpackage

// >>> isa_timeout.sv
// serial clock low timeout detector with a microsecond tick divider
`timescale 1ns/1ns
`default_nettype none
module isa_timeout
    import isa_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int LIMIT_TICKS = TIMEOUT_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // line state
    input wire logic enable,
    input wire logic sclLow,
    // one-cycle pulse when the limit is reached
    output logic expired
);

    logic [TICK_W-1:0] divCount;
    logic [TICK_W-1:0] tickCount;
    logic armed;
    wire running = enable && sclLow && armed;
    wire tick = running && (divCount == TICK_W'(TICK_LEN - 1));
    wire atLimit = tick && (tickCount == TICK_W'(LIMIT_TICKS - 1));

    always_ff @(posedge clk) begin
        if (!rst_n || !running) begin
            divCount <= '0;
        end else if (tick) begin
            divCount <= '0;
        end else begin
            divCount <= divCount + TICK_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n || !running) begin
            tickCount <= '0;
        end else if (tick) begin
            tickCount <= tickCount + TICK_W'(1);
        end
    end

    // one report per low period: rearm once the line goes high or the detector is disabled
    always_ff @(posedge clk) begin
        if (!rst_n || !enable || !sclLow) begin
            armed <= 1'b1;
        end else if (atLimit) begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            expired <= 1'b0;
        end else begin
            expired <= atLimit; // see RL4
        end
    end

endmodule
`default_nettype wire

// >>> isa_regs.sv
// second address, data buffer and transfer status registers of the two-wire controller
// Notes on behaviour
// RL1 - with dual addressing on, a slave also answers the 7-bit second address.
// RL2 - the data buffer holds one byte, sent when written and received when read.
// RL3 - the alert flag sets on a low alert pin as device or a detected alert as host.
// RL4 - in SMBus mode the timeout flag sets after the clock line stays low 25 ms.
// RL5 - a PEC mismatch sets its flag and forces a not-acknowledge regardless of ack_enable.
// RL6 - slave receive without stretching flags overrun when a byte lands on an unread one.
// RL7 - slave transmit without stretching flags underrun when a byte ends on an empty buffer.
// RL8 - error flags are set only by hardware and software clears one by writing zero.
// RL9 - a missing expected acknowledge sets the acknowledge error flag.
// RL10 - lost arbitration as master sets its flag and drops back to slave mode.
// RL11 - an unexpected start or stop sets the bus error flag.
// RL12 - tx_buffer_empty rises when the byte goes to the shifter and drops on a new write.
// RL13 - the status register resets to zero and takes full-width reads and writes.
// RL14 - rx_buffer_not_empty rises when a byte enters the buffer and clears on a read.
// RL15 - with shifter and buffer both empty a buffer write leaves tx_buffer_empty set.
// RL16 - writing one to a write-zero flag and writing read-only flags change nothing.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module isa_regs
    import isa_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int LIMIT_TICKS = TIMEOUT_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData,
    // mode levels
    input wire isa_mode_t mode,
    // bus pins, sampled
    input wire logic sclIn,
    input wire logic smbusAlertPinN,
    // protocol engine events
    input wire isa_engine_t eng,
    // answers to the protocol engine
    output logic secondAddrMatch,
    output logic forceNack,
    output logic dropToSlave,
    output logic [7:0] txByte,
    output logic txByteValid,
    output logic txBufferEmpty,
    output logic rxBufferNotEmpty
);

    // register state
    logic [ADDR2_MSB:ADDR2_LSB] secondSlaveAddr;
    logic dualAddrEnable;
    logic [7:0] transferByte;
    logic [15:0] status;

    // address decode
    wire selAddr2 = (regAddr == OFS_SECOND_ADDR);
    wire selData = (regAddr == OFS_DATA_BUF);
    wire selStatus = (regAddr == OFS_STATUS0);
    wire wrAddr2 = regWrite && selAddr2;
    wire wrData = regWrite && selData;
    wire wrStatus = regWrite && selStatus;
    wire rdData = regRead && selData;

    // flag views
    wire txEmpty = status[BIT_TBE];
    wire rxFull = status[BIT_RX_BUFFER_NOT_EMPTY];
    wire noStretch = mode.stretchDisable;

    // timeout detector
    logic timeoutHit;

    isa_timeout #(
        .TICK_LEN(TICK_LEN),
        .LIMIT_TICKS(LIMIT_TICKS)
    ) timeoutUnit (
        .clk(clk),
        .rst_n(rst_n),
        .enable(mode.smbusMode),
        .sclLow(!sclIn),
        .expired(timeoutHit)
    );

    // event decode
    // device mode reports the pin level, host mode relies on the engine's detection
    wire alertEvent = mode.smbusMode &&
        (mode.smbusHost ? eng.alertDetected : !smbusAlertPinN); // see RL3
    wire timeoutEvent = mode.smbusMode && timeoutHit; // see RL4
    wire pecEvent = eng.pecMismatch; // see RL5
    wire overrunEvent = mode.slaveRx && noStretch && eng.rxByteDone && rxFull; // see RL6
    wire underrunEvent = mode.slaveTx && noStretch && eng.txShiftDone && txEmpty; // see RL7
    wire ackEvent = eng.ackMissing; // see RL9
    wire arbEvent = mode.isMaster && eng.arbLost; // see RL10
    wire busErrEvent = eng.badStartStop; // see RL11

    // transmit path
    // a write while both shifter and buffer are empty goes straight to the shifter
    wire wrDirect = wrData && txEmpty && eng.shiftEmpty; // see RL15
    wire engineTakes = eng.txByteTaken && !txEmpty;
    wire tbeSet = engineTakes; // see RL12
    wire tbeClear = wrData && !wrDirect; // see RL12

    // receive path
    // on overrun the unread byte is kept and the new one is lost
    wire rxAccept = eng.rxByteDone && !overrunEvent;
    wire rbneSet = rxAccept; // see RL14
    wire rbneClear = rdData; // see RL14

    // hardware set vector and clear vector from buffer accesses and written zeros
    logic [15:0] setVec;
    logic [15:0] clrVec;

    always_comb begin
        setVec = RST_STATUS0;
        setVec[BIT_ALERT] = alertEvent;
        setVec[BIT_TIMEOUT] = timeoutEvent;
        setVec[BIT_PEC] = pecEvent;
        setVec[BIT_OVR_UND] = overrunEvent || underrunEvent;
        setVec[BIT_ACK_ERR] = ackEvent;
        setVec[BIT_ARB_LOST] = arbEvent;
        setVec[BIT_BUS_ERR] = busErrEvent;
        setVec[BIT_TBE] = tbeSet;
        setVec[BIT_RX_BUFFER_NOT_EMPTY] = rbneSet;
    end

    always_comb begin
        clrVec = RST_STATUS0;
        clrVec[BIT_TBE] = tbeClear;
        clrVec[BIT_RX_BUFFER_NOT_EMPTY] = rbneClear;
        // only a written zero clears, ones and read-only bits are ignored
        if (wrStatus) begin
            clrVec = clrVec | (CLEAR_W0_MASK & ~regWrData[15:0]); // see RL8 RL16
        end
    end

    // status bits, set wins over a clear in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : gFlag
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    status[gi] <= RST_STATUS0[gi]; // see RL13
                end else if (setVec[gi]) begin
                    status[gi] <= 1'b1; // see RL8
                end else if (clrVec[gi]) begin
                    status[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // second address register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            secondSlaveAddr <= RST_SECOND_ADDR[ADDR2_MSB:ADDR2_LSB];
            dualAddrEnable <= RST_SECOND_ADDR[DUAL_EN_BIT];
        end else if (wrAddr2) begin
            secondSlaveAddr <= regWrData[ADDR2_MSB:ADDR2_LSB];
            dualAddrEnable <= regWrData[DUAL_EN_BIT];
        end
    end

    // data buffer, shared by both directions
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            transferByte <= RST_DATA_BUF;
        end else if (rxAccept) begin
            transferByte <= eng.rxByte; // see RL2
        end else if (wrData) begin
            transferByte <= regWrData[7:0]; // see RL2
        end
    end

    // shifter load towards the engine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txByte <= RST_DATA_BUF;
            txByteValid <= 1'b0;
        end else begin
            txByteValid <= engineTakes || wrDirect;
            if (wrDirect) begin
                txByte <= regWrData[7:0];
            end else if (engineTakes) begin
                txByte <= transferByte;
            end
        end
    end

    // address compare against the second address
    wire addr2Hit = dualAddrEnable && eng.addrValid &&
        (eng.addrByte[ADDR2_MSB:ADDR2_LSB] == secondSlaveAddr);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            secondAddrMatch <= 1'b0;
            forceNack <= 1'b0;
            dropToSlave <= 1'b0;
        end else begin
            secondAddrMatch <= addr2Hit; // see RL1
            forceNack <= pecEvent; // see RL5
            dropToSlave <= arbEvent; // see RL10
        end
    end

    // flag copies for the engine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txBufferEmpty <= RST_STATUS0[BIT_TBE];
            rxBufferNotEmpty <= RST_STATUS0[BIT_RX_BUFFER_NOT_EMPTY];
        end else begin
            txBufferEmpty <= (status[BIT_TBE] || setVec[BIT_TBE]) &&
                !(clrVec[BIT_TBE] && !setVec[BIT_TBE]);
            rxBufferNotEmpty <= (status[BIT_RX_BUFFER_NOT_EMPTY] || setVec[BIT_RX_BUFFER_NOT_EMPTY]) &&
                !(clrVec[BIT_RX_BUFFER_NOT_EMPTY] && !setVec[BIT_RX_BUFFER_NOT_EMPTY]);
        end
    end

    // read mux, narrow registers in the low bits, unmapped reads zero
    wire [31:0] rdAddr2 = {16'h0000, 8'h00, secondSlaveAddr, dualAddrEnable};
    wire [31:0] rdDataBuf = {16'h0000, 8'h00, transferByte};
    wire [31:0] rdStatus = {16'h0000, status}; // see RL13
    wire [31:0] rdMux = selAddr2 ? rdAddr2 :
        selData ? rdDataBuf :
        selStatus ? rdStatus : READ_ZERO;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdData <= READ_ZERO;
        end else if (regRead) begin
            regRdData <= rdMux;
        end else begin
            regRdData <= READ_ZERO;
        end
    end

endmodule
`default_nettype wire

// >>> isa_regs_checker.sv
// concurrent checks on the register block ports
`timescale 1ns/1ns
`default_nettype none
module isa_regs_checker
    import isa_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES,
    parameter int LIMIT_TICKS = TIMEOUT_TICKS
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdData,
    // engine side
    input wire isa_mode_t mode,
    input wire logic sclIn,
    input wire logic smbusAlertPinN,
    input wire isa_engine_t eng,
    input wire logic secondAddrMatch,
    input wire logic forceNack,
    input wire logic dropToSlave,
    input wire logic [7:0] txByte,
    input wire logic txByteValid,
    input wire logic txBufferEmpty,
    input wire logic rxBufferNotEmpty
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire dataWr = regWrite && regAddr == OFS_DATA_BUF;
    wire dataRd = regRead && regAddr == OFS_DATA_BUF;
    // last value written to the second address register, seen from the port
    logic [7:0] addr2Shadow;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr2Shadow <= 8'h00;
        end else if (regWrite && regAddr == OFS_SECOND_ADDR) begin
            addr2Shadow <= regWrData[7:0];
        end
    end
    sequence s_rx_land;
        eng.rxByteDone && !rxBufferNotEmpty;
    endsequence
    sequence s_buf_read;
        dataRd && !eng.rxByteDone;
    endsequence
    a_rx_byte_read: assert property (s_rx_land ##1 s_buf_read |=>
        regRdData[7:0] == $past(eng.rxByte, 2)) else $error("rx byte lost");
    a_read_one_cycle: assert property (regRdData != 32'h0000_0000 |->
        $past(regRead)) else $error("read data outside its cycle");
    a_pec_nack: assert property (eng.pecMismatch |=> forceNack)
        else $error("no nack after pec mismatch");
    a_arb_drop: assert property (eng.arbLost && mode.isMaster |=> dropToSlave)
        else $error("no drop to slave");
    a_addr_cause: assert property (secondAddrMatch |-> $past(eng.addrValid))
        else $error("address match without address");
    a_addr_compare: assert property (eng.addrValid |=>
        secondAddrMatch == ($past(addr2Shadow[DUAL_EN_BIT]) &&
        $past(eng.addrByte[ADDR2_MSB:ADDR2_LSB]) == $past(addr2Shadow[ADDR2_MSB:ADDR2_LSB])))
        else $error("second address compare wrong");
    a_tbe_write: assert property (txBufferEmpty && dataWr && !eng.shiftEmpty
        |=> !txBufferEmpty) else $error("tbe kept after write");
    a_tbe_idle: assert property (txBufferEmpty && dataWr && eng.shiftEmpty |=>
        txBufferEmpty && txByteValid && txByte == $past(regWrData[7:0]))
        else $error("idle write lost");
    a_tbe_take: assert property (!txBufferEmpty && eng.txByteTaken |=>
        txBufferEmpty && txByteValid) else $error("tbe not set on take");
    a_rx_buffer_not_empty_set: assert property (eng.rxByteDone |=> rxBufferNotEmpty)
        else $error("rx_buffer_not_empty not set");
    a_rx_buffer_not_empty_clear: assert property (rxBufferNotEmpty && dataRd && !eng.rxByteDone
        |=> !rxBufferNotEmpty) else $error("rx_buffer_not_empty not cleared");
endmodule
bind isa_regs isa_regs_checker #(.TICK_LEN(TICK_LEN), .LIMIT_TICKS(LIMIT_TICKS)) i_chk (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .mode(mode),
    .sclIn(sclIn), .smbusAlertPinN(smbusAlertPinN), .eng(eng),
    .secondAddrMatch(secondAddrMatch), .forceNack(forceNack), .dropToSlave(dropToSlave),
    .txByte(txByte), .txByteValid(txByteValid), .txBufferEmpty(txBufferEmpty),
    .rxBufferNotEmpty(rxBufferNotEmpty));
`default_nettype wire

// >>> isa_bus_model.sv
// far-side engine model: turns bench requests into one-cycle bus events
`timescale 1ns/1ns
`default_nettype none
module isa_bus_model
    import isa_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // requests from the bench
    input wire logic [3:0] evKind,
    input wire logic [7:0] evByte,
    input wire logic evGo,
    input wire logic idleShift,
    // events towards the register block
    output var isa_engine_t eng
);
    always_ff @(posedge clk) begin
        eng <= '0;
        eng.shiftEmpty <= idleShift;
        // bytes outside a pulse are inverted so a stale value never matches
        eng.addrByte <= evGo ? evByte : ~evByte;
        eng.rxByte <= evGo ? evByte : ~evByte;
        if (rst_n && evGo) begin
            case (evKind)
                4'h0: eng.addrValid <= 1'b1;
                4'h1: eng.rxByteDone <= 1'b1;
                4'h2: eng.txByteTaken <= 1'b1;
                4'h3: eng.txShiftDone <= 1'b1;
                4'h4: eng.alertDetected <= 1'b1;
                4'h5: eng.pecMismatch <= 1'b1;
                4'h6: eng.ackMissing <= 1'b1;
                4'h7: eng.arbLost <= 1'b1;
                default: eng.badStartStop <= 1'b1;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> isa_regs_test.sv
// self-checking bench for the status and address register block
`timescale 1ns/1ns
`default_nettype none
module isa_regs_test import isa_pkg::*;;
    logic clk = 0;
    logic rst_n = 0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic regWrite = 0, regRead = 0, sclIn = 1, alertN = 1, evGo = 0, idleShift = 0;
    logic [31:0] regRdData;
    isa_mode_t mode = '0;
    logic [3:0] evKind = 4'h0;
    logic [7:0] evByte = 8'h00, b, c, txByte;
    isa_engine_t eng;
    logic addrHit, tbeOut, rbneOut;
    int numErrors = 0, comparisons = 0;
    int kinds[5] = '{4, 5, 6, 7, 8};
    int bits[5] = '{BIT_ALERT, BIT_PEC, BIT_ACK_ERR, BIT_ARB_LOST, BIT_BUS_ERR};
    isa_regs #(.TICK_LEN(4), .LIMIT_TICKS(5)) i_isa_regs (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .mode(mode),
        .sclIn(sclIn), .smbusAlertPinN(alertN), .eng(eng), .secondAddrMatch(addrHit),
        .forceNack(), .dropToSlave(), .txByte(txByte), .txByteValid(),
        .txBufferEmpty(tbeOut), .rxBufferNotEmpty(rbneOut));
    isa_bus_model i_isa_bus_model (.clk(clk), .rst_n(rst_n), .evKind(evKind),
        .evByte(evByte), .evGo(evGo), .idleShift(idleShift), .eng(eng));
    initial begin
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] bitOf(input int n);
        return 32'h0000_0001 << n;
    endfunction
    function automatic logic [31:0] wide(input logic [7:0] v);
        return {24'h00_0000, v};
    endfunction
    task automatic conclude();
        $display("errors %0d, comparisons %0d", numErrors, comparisons);
        if (numErrors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            numErrors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(n, e, regRdData);
    endtask
    task automatic ev(input logic [3:0] k, input logic [7:0] v);
        @(posedge clk);
        evKind <= k;
        evByte <= v;
        evGo <= 1'b1;
        @(posedge clk);
        evGo <= 1'b0;
    endtask
    task automatic hit(input logic [7:0] v, input logic e);
        ev(4'h0, v);
        @(posedge clk);
        #1 chk("match", wide({7'h00, e}), wide({7'h00, addrHit}));
    endtask
    initial begin
        #200_000 numErrors++;
        conclude();
    end
    initial begin
        void'($urandom(97));
        b = 8'($urandom());
        // c always differs from b so a dropped or stale byte shows up
        c = b ^ 8'($urandom_range(255, 1));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdc("status", OFS_STATUS0, 32'h0000_0000);
        rdc("addr2", OFS_SECOND_ADDR, 32'h0000_0000);
        rdc("unmapped", 8'h18, 32'h0000_0000);
        wr(OFS_SECOND_ADDR, wide({b[7:1], 1'b1}));
        rdc("addr2", OFS_SECOND_ADDR, wide({b[7:1], 1'b1}));
        hit(b, 1'b1);
        hit(b ^ 8'h02, 1'b0);
        wr(OFS_SECOND_ADDR, wide({b[7:1], 1'b0}));
        hit(b, 1'b0);
        @(posedge clk);
        mode <= 6'h31;
        foreach (kinds[i]) begin
            ev(4'(kinds[i]), 8'h00);
            rdc("flag", OFS_STATUS0, bitOf(bits[i]));
            wr(OFS_STATUS0, 32'h0000_ffff);
            rdc("flag kept", OFS_STATUS0, bitOf(bits[i]));
            wr(OFS_STATUS0, ~bitOf(bits[i]));
            rdc("flag clear", OFS_STATUS0, 32'h0000_0000);
        end
        @(posedge clk);
        mode <= 6'h20;
        sclIn <= 1'b0;
        rdc("early", OFS_STATUS0, 32'h0000_0000);
        repeat (17) @(posedge clk);
        rdc("near limit", OFS_STATUS0, 32'h0000_0000);
        rdc("timeout", OFS_STATUS0, bitOf(BIT_TIMEOUT));
        @(posedge clk);
        sclIn <= 1'b1;
        alertN <= 1'b0;
        @(posedge clk);
        alertN <= 1'b1;
        wr(OFS_STATUS0, ~bitOf(BIT_TIMEOUT));
        rdc("alert pin", OFS_STATUS0, bitOf(BIT_ALERT));
        wr(OFS_STATUS0, 32'h0000_0000);
        mode <= 6'h0c;
        ev(4'h1, b);
        // read straight after the byte lands so the receive path is seen end to end
        rdc("rx byte", OFS_DATA_BUF, wide(b));
        rdc("rx_buffer_not_empty clear", OFS_STATUS0, 32'h0000_0000);
        ev(4'h1, b);
        rdc("rx_buffer_not_empty", OFS_STATUS0, bitOf(BIT_RX_BUFFER_NOT_EMPTY));
        chk("rx_buffer_not_empty pin", 32'h0000_0001, wide({7'h00, rbneOut}));
        ev(4'h1, c);
        rdc("overrun", OFS_STATUS0, bitOf(BIT_OVR_UND) | bitOf(BIT_RX_BUFFER_NOT_EMPTY));
        rdc("old byte", OFS_DATA_BUF, wide(b));
        wr(OFS_STATUS0, 32'h0000_0000);
        mode <= 6'h0a;
        wr(OFS_DATA_BUF, wide(b));
        ev(4'h2, 8'h00);
        rdc("tbe", OFS_STATUS0, bitOf(BIT_TBE));
        chk("tx byte", wide(b), wide(txByte));
        chk("tbe pin", 32'h0000_0001, wide({7'h00, tbeOut}));
        @(posedge clk);
        idleShift <= 1'b1;
        wr(OFS_DATA_BUF, wide(c));
        rdc("tbe idle", OFS_STATUS0, bitOf(BIT_TBE));
        chk("tx direct", wide(c), wide(txByte));
        @(posedge clk);
        idleShift <= 1'b0;
        wr(OFS_DATA_BUF, wide(b));
        rdc("tbe clear", OFS_STATUS0, 32'h0000_0000);
        ev(4'h2, 8'h00);
        ev(4'h3, 8'h00);
        rdc("underrun", OFS_STATUS0, bitOf(BIT_OVR_UND) | bitOf(BIT_TBE));
        // reset in mid-run must drop the flags and the shifter byte
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc("reset status", OFS_STATUS0, 32'h0000_0000);
        chk("reset tx byte", 32'h0000_0000, wide(txByte));
        conclude();
    end
endmodule
`default_nettype wire
